// ### src/iapd_ctrl.sv
// Auto powerdown control for the floppy, serial and parallel blocks.
// Assumes host strobes and core status come synchronous to mclk from device logic.
`timescale 1ns/100ps
`include "iapd_map.svh"
module iapd_ctrl
   import iapd_pkg::*;
#(
   parameter int IDLE_CYCLES = `IAPD_IDLE_CYCLES,
   parameter int NSER = 2
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire iapd_host_t host,
   output logic [7:0] host_rdata,
   input wire logic [7:0] status_a_live,
   input wire logic [7:0] status_b_live,
   input wire logic [7:0] main_status_live,
   input wire logic [7:0] data_live,
   input wire logic [7:0] dir_live,
   input wire logic fdc_int,
   input wire logic head_unload_done,
   input wire logic [7:0] auto_power_config,
   input wire logic core_irq,
   input wire logic core_drq,
   output logic interrupt_request_out,
   output logic dma_request_out,
   input wire iapd_drive_t core_drive,
   output iapd_drive_t drive_out,
   output iapd_drive_t drive_oe,
   input wire logic [5:0] drive_inputs_pin,
   output logic [5:0] drive_inputs,
   input wire iapd_local_t core_local,
   output iapd_local_t local_out,
   output logic [7:0] dmc_value,
   output logic [7:0] ccr_value,
   output logic fdc_powered_down,
   input wire logic [NSER-1:0] tx_buf_write,
   input wire logic [NSER-1:0] tx_empty,
   input wire logic [NSER-1:0] rx_fifo_empty,
   input wire logic [NSER-1:0] rx_idle,
   input wire logic [NSER-1:0] serial_receive_in,
   input wire logic [NSER-1:0] ring_indicator_in,
   output logic [NSER-1:0] ring_change,
   output logic [NSER-1:0] tx_powered_down,
   output logic [NSER-1:0] rx_powered_down,
   input wire logic epp_enabled,
   input wire logic ecp_enabled,
   input wire logic [2:0] ecr_mode,
   output logic epp_powered_down,
   output logic ecp_powered_down
);

   // ************************************************************
   // Floppy access decode
   // ************************************************************
   logic wr_dmc;
   logic wr_rate;
   logic wr_ccr;
   logic wake_access;
   logic wake_write;
   logic rd_any;
   logic [7:0] dmc_reg;
   logic [7:0] ccr_reg;
   logic [7:0] drive_in_s1;
   logic [7:0] drive_in_s2;

   assign wr_dmc = host.wr && host.addr == `IAPD_OFS_DMC;
   assign wr_rate = host.wr && host.addr == `IAPD_OFS_RATE;
   assign wr_ccr = host.wr && host.addr == `IAPD_OFS_DIR_CCR;
   assign rd_any = host.rd;
   // Only main status reads and data accesses wake on their own; control writes wake only as below.
   assign wake_access = (host.rd && host.addr == `IAPD_OFS_RATE) ||
                        ((host.rd || host.wr) && host.addr == `IAPD_OFS_DATA);
   // Control writes wake on a motor bit or a software reset.
   assign wake_write = (wr_dmc && (host.wdata[`IAPD_DMC_MOT_HI:`IAPD_DMC_MOT_LO] != 4'h0 ||
                                   !host.wdata[`IAPD_DMC_RST_N_BIT])) ||
                       (wr_rate && host.wdata[`IAPD_RATE_SWRST_BIT]);

   // ************************************************************
   // Stored control values
   // ************************************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dmc_reg <= `IAPD_DMC_RESET;
      end else if (wr_dmc) begin
         dmc_reg <= host.wdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ccr_reg <= 8'h00;
      end else if (wr_ccr) begin
         ccr_reg <= host.wdata;
      end
   end

   // Stored values reach the core only while awake, so sleeping writes apply on wake.
   logic [7:0] dmc_held_reg;
   logic [7:0] ccr_held_reg;

   // ************************************************************
   // Floppy power state
   // ************************************************************
   iapd_state_t state_reg;
   iapd_state_t state_next;
   logic [31:0] idle_cnt_reg;
   logic idle_done;
   logic idle_ok;
   logic auto_en;
   logic asleep;

   assign auto_en = auto_power_config[`IAPD_CFG_FDC_BIT];
   assign idle_done = idle_cnt_reg >= IDLE_CYCLES;
   assign idle_ok = auto_en && dmc_reg[`IAPD_DMC_MOT_HI:`IAPD_DMC_MOT_LO] == 4'h0 &&
                    main_status_live == `IAPD_MSR_IDLE && !fdc_int &&
                    head_unload_done && idle_done;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         idle_cnt_reg <= 32'h0;
      end else if (!auto_en || wake_access || wake_write || state_reg == IAPD_DIRECT) begin
         idle_cnt_reg <= 32'h0;
      end else if (!idle_done) begin
         idle_cnt_reg <= idle_cnt_reg + 32'h1;
      end
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         IAPD_AWAKE: begin
            if (auto_en) begin
               state_next = IAPD_ARMED;
            end
         end
         IAPD_ARMED: begin
            if (!auto_en) begin
               state_next = IAPD_AWAKE;
            end else if (idle_ok && !wake_access && !wake_write) begin
               state_next = IAPD_DOWN;
            end
         end
         IAPD_DOWN: begin
            if (!auto_en || wake_access || wake_write) begin
               state_next = IAPD_ARMED;
            end
         end
         IAPD_DIRECT: begin
            if (wake_access || wake_write) begin
               state_next = IAPD_ARMED;
            end
         end
         default: begin
            state_next = IAPD_AWAKE;
         end
      endcase
      // Direct powerdown through the rate register wins over any auto state.
      if (wr_rate && host.wdata[`IAPD_RATE_PD_BIT] && !host.wdata[`IAPD_RATE_SWRST_BIT]) begin
         state_next = IAPD_DIRECT;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= IAPD_AWAKE;
      end else begin
         state_reg <= state_next;
      end
   end

   // A waking access moves the state from DOWN to ARMED, so the part drops back by itself.
   assign asleep = state_reg == IAPD_DOWN || state_reg == IAPD_DIRECT;
   assign fdc_powered_down = asleep;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dmc_held_reg <= `IAPD_DMC_RESET;
         ccr_held_reg <= 8'h00;
      end else if (!asleep) begin
         dmc_held_reg <= dmc_reg;
         ccr_held_reg <= ccr_reg;
      end
   end
   assign dmc_value = dmc_held_reg;
   assign ccr_value = ccr_held_reg;

   // ************************************************************
   // Host read path
   // ************************************************************
   // Reads show live status, sleeping or not, except the DMC offset, which returns the stored dmc_reg.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         host_rdata <= 8'h00;
      end else if (rd_any) begin
         case (host.addr)
            `IAPD_OFS_STAT_A: host_rdata <= status_a_live;
            `IAPD_OFS_STAT_B: host_rdata <= status_b_live;
            `IAPD_OFS_DMC: host_rdata <= dmc_reg;
            `IAPD_OFS_RATE: host_rdata <= main_status_live;
            `IAPD_OFS_DATA: host_rdata <= data_live;
            `IAPD_OFS_DIR_CCR: host_rdata <= dir_live;
            default: host_rdata <= 8'h00;
         endcase
      end
   end

   // ************************************************************
   // Pins in powerdown
   // ************************************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_request_out <= 1'b0;
         dma_request_out <= 1'b0;
         drive_out <= '0;
         local_out <= '0;
      end else begin
         interrupt_request_out <= core_irq && !asleep;
         dma_request_out <= core_drq && !asleep;
         drive_out <= core_drive;
         local_out <= core_local;
      end
   end
   assign drive_oe = asleep ? '0 : '1;

   // Drive pins arrive from outside and pass two flops before use.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         drive_in_s1 <= 8'h00;
         drive_in_s2 <= 8'h00;
      end else begin
         drive_in_s1 <= {2'b00, drive_inputs_pin};
         drive_in_s2 <= drive_in_s1;
      end
   end
   // Gating the inputs keeps floating cable levels out of the core.
   assign drive_inputs = asleep ? 6'h00 : drive_in_s2[5:0];

   // ************************************************************
   // Serial ports
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < NSER; g++) begin : g_ser
         logic rx_s1;
         logic rx_s2;
         logic rx_d;
         logic ri_s1;
         logic ri_s2;
         logic ri_d;
         logic ser_en;
         logic tx_pd_reg;
         logic rx_pd_reg;
         assign ser_en = auto_power_config[`IAPD_CFG_SER1_BIT + g];

         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               rx_s1 <= 1'b1;
               rx_s2 <= 1'b1;
               rx_d <= 1'b1;
               ri_s1 <= 1'b0;
               ri_s2 <= 1'b0;
               ri_d <= 1'b0;
            end else begin
               rx_s1 <= serial_receive_in[g];
               rx_s2 <= rx_s1;
               rx_d <= rx_s2;
               ri_s1 <= ring_indicator_in[g];
               ri_s2 <= ri_s1;
               ri_d <= ri_s2;
            end
         end
         // Ring detection runs regardless of powerdown.
         assign ring_change[g] = ri_s2 ^ ri_d;

         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               tx_pd_reg <= 1'b0;
            end else if (!ser_en || tx_buf_write[g]) begin
               tx_pd_reg <= 1'b0;
            end else if (tx_empty[g]) begin
               tx_pd_reg <= 1'b1;
            end
         end

         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               rx_pd_reg <= 1'b0;
            end else if (!ser_en || (rx_s2 != rx_d)) begin
               rx_pd_reg <= 1'b0;
            end else if (rx_fifo_empty[g] && rx_idle[g]) begin
               rx_pd_reg <= 1'b1;
            end
         end
         assign tx_powered_down[g] = tx_pd_reg;
         assign rx_powered_down[g] = rx_pd_reg;
      end
   endgenerate

   // ************************************************************
   // Parallel port
   // ************************************************************
   // Evaluated every cycle, so any mode or config change takes effect next edge.
   logic par_en;
   logic ecp_other;
   assign par_en = auto_power_config[`IAPD_CFG_PAR_BIT];
   assign ecp_other = ecr_mode == `IAPD_ECR_SPP || ecr_mode == `IAPD_ECR_BIDIR ||
                      ecr_mode == `IAPD_ECR_EPP;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         epp_powered_down <= 1'b0;
         ecp_powered_down <= 1'b0;
      end else begin
         epp_powered_down <= par_en && (!epp_enabled ||
                             (ecp_enabled && ecr_mode != `IAPD_ECR_EPP));
         ecp_powered_down <= par_en && (!ecp_enabled || ecp_other);
      end
   end

endmodule : iapd_ctrl

// ### src/iapd_map.svh
// Register offsets, field positions and timing figures for the auto powerdown control.
// Assumes inclusion by bare name from the package and the design module.
`ifndef IAPD_MAP_SVH
`define IAPD_MAP_SVH
`define IAPD_OFS_STAT_A 3'h0
`define IAPD_OFS_STAT_B 3'h1
`define IAPD_OFS_DMC 3'h2
`define IAPD_OFS_RATE 3'h4
`define IAPD_OFS_DATA 3'h5
`define IAPD_OFS_DIR_CCR 3'h7
`define IAPD_DMC_RST_N_BIT 2
`define IAPD_DMC_MOT_LO 4
`define IAPD_DMC_MOT_HI 7
`define IAPD_RATE_SWRST_BIT 7
`define IAPD_RATE_PD_BIT 6
`define IAPD_MSR_IDLE 8'h80
`define IAPD_CFG_FDC_BIT 0
`define IAPD_CFG_PAR_BIT 3
`define IAPD_CFG_SER1_BIT 4
`define IAPD_CFG_SER2_BIT 5
`define IAPD_IDLE_TIME_MS 10
`define IAPD_CLK_MHZ 100
`define IAPD_IDLE_CYCLES (`IAPD_IDLE_TIME_MS * 1000 * `IAPD_CLK_MHZ)
`define IAPD_DMC_RESET 8'h04
`define IAPD_ECR_SPP 3'h0
`define IAPD_ECR_BIDIR 3'h1
`define IAPD_ECR_EPP 3'h4
`endif

// ### src/iapd_pkg.sv
// Types shared by the auto powerdown control and its surroundings.
// Assumes the map header sits on the include path.
`include "iapd_map.svh"
package iapd_pkg;
   typedef enum logic [1:0] {
      IAPD_AWAKE = 2'b00,
      IAPD_ARMED = 2'b01,
      IAPD_DOWN = 2'b11,
      IAPD_DIRECT = 2'b10
   } iapd_state_t;
   typedef struct packed {
      logic [3:0] motor_enables;
      logic [3:0] drive_selects;
      logic write_data_out;
      logic write_gate_out;
   } iapd_drive_t;
   typedef struct packed {
      logic step_dir_out;
      logic step_out;
      logic head_select_out;
      logic density_select_out;
      logic [1:0] rate_select_out;
   } iapd_local_t;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [2:0] addr;
      logic [7:0] wdata;
   } iapd_host_t;
endpackage : iapd_pkg

// ### dv/iapd_ctrl_asserts.sv
// Concurrent checks on the ports of the auto powerdown control.
// Assumes it is bound to iapd_ctrl and that every check lives in the mclk domain.
`timescale 1ns/100ps
module iapd_ctrl_asserts
   import iapd_pkg::*;
#(
   parameter int NSER = 2
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire iapd_host_t host,
   input wire logic [7:0] host_rdata,
   input wire logic [7:0] status_a_live,
   input wire logic [7:0] auto_power_config,
   input wire logic interrupt_request_out,
   input wire logic dma_request_out,
   input wire iapd_drive_t drive_oe,
   input wire iapd_local_t core_local,
   input wire iapd_local_t local_out,
   input wire logic fdc_powered_down,
   input wire logic [NSER-1:0] tx_buf_write,
   input wire logic [NSER-1:0] tx_powered_down,
   input wire logic [NSER-1:0] ring_indicator_in,
   input wire logic [NSER-1:0] ring_change,
   input wire logic epp_enabled,
   input wire logic epp_powered_down
);
   // ********************************
   // Port relations
   // ********************************
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   AST_RDATA_LIVE: assert property (host.rd && host.addr == 3'h0 |=>
      host_rdata == $past(status_a_live)) else $error("status read data not live.");
   AST_WAKE_ACCESS: assert property ((host.rd && host.addr == 3'h4) ||
      ((host.rd || host.wr) && host.addr == 3'h5) |=> !fdc_powered_down)
      else $error("waking access left block down.");
   AST_STAY_DOWN: assert property (fdc_powered_down && host.rd &&
      host.addr inside {3'h0, 3'h1, 3'h2, 3'h7} |=> fdc_powered_down)
      else $error("status read woke the block.");
   AST_MOTOR_WAKE: assert property (host.wr && host.addr == 3'h2 &&
      host.wdata[7:4] != 4'h0 |=> !fdc_powered_down) else $error("motor write did not wake.");
   AST_REQ_LOW: assert property ($past(fdc_powered_down) |->
      !interrupt_request_out && !dma_request_out) else $error("request output high asleep.");
   AST_DRIVE_OE: assert property (drive_oe ==
      {$bits(iapd_drive_t){!fdc_powered_down}}) else $error("drive enables wrong.");
   AST_LOCAL: assert property ($past(rst_n) |-> local_out == $past(core_local))
      else $error("local control pin not driven.");
   AST_TX_WAKE: assert property (tx_buf_write[0] |=> !tx_powered_down[0])
      else $error("transmitter stayed down after buffer write.");
   AST_EPP_OFF: assert property (auto_power_config[3] && !epp_enabled |=>
      epp_powered_down) else $error("disabled parallel logic not down.");
   AST_RING: assert property ($changed(ring_indicator_in[0]) |->
      ##[1:4] ring_change[0]) else $error("ring change not reported.");
endmodule : iapd_ctrl_asserts

bind iapd_ctrl iapd_ctrl_asserts #(.NSER(NSER)) u_chk (.mclk, .rst_n, .host, .host_rdata,
   .status_a_live, .auto_power_config, .interrupt_request_out, .dma_request_out, .drive_oe,
   .core_local, .local_out, .fdc_powered_down, .tx_buf_write, .tx_powered_down,
   .ring_indicator_in, .ring_change, .epp_enabled, .epp_powered_down);

// ### dv/iapd_host_bfm.sv
// Host model issuing single-cycle I/O reads and writes.
// Assumes the caller starts each transfer from any point of the mclk cycle.
`timescale 1ns/100ps
module iapd_host_bfm
   import iapd_pkg::*;
(
   input wire logic mclk,
   output iapd_host_t host
);
   initial host = '0;
   // ********************************
   // Transfers
   // ********************************
   // A request spans one rising edge; an idle cycle follows so strobes never merge.
   task automatic xfer(input logic rd, input logic wr, input logic [2:0] a, input logic [7:0] d);
      @(negedge mclk);
      host <= '{rd: rd, wr: wr, addr: a, wdata: d};
      @(negedge mclk);
      // A released data bus floats, so the stale byte is inverted rather than kept.
      host <= '{rd: 1'b0, wr: 1'b0, addr: a, wdata: ~d};
   endtask : xfer
endmodule : iapd_host_bfm

// ### dv/tb_io_auto_powerdown_control.sv
// Self-checking bench for the auto powerdown control.
// Assumes the design package, map header and host model are compiled first.
`timescale 1ns/100ps
`include "iapd_map.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
   $display("unexpected at %0t got %h exp %h", $time, (a), (e)); end end
module tb_io_auto_powerdown_control;
   import iapd_pkg::*;
   logic mclk = 1'b0;
   logic rst_n, fdc_int, head_unload_done, core_irq, core_drq, interrupt_request_out;
   logic dma_request_out, fdc_powered_down, epp_enabled, ecp_enabled, epp_powered_down;
   logic ecp_powered_down, rd_seen = 1'b0;
   logic [7:0] host_rdata, status_a_live, status_b_live, main_status_live, data_live;
   logic [7:0] dir_live, auto_power_config, dmc_value, ccr_value;
   logic [5:0] drive_inputs_pin, drive_inputs;
   logic [2:0] ecr_mode;
   logic [1:0] tx_buf_write, tx_empty, rx_fifo_empty, rx_idle, serial_receive_in;
   logic [1:0] ring_indicator_in, ring_change, tx_powered_down, rx_powered_down;
   iapd_host_t host;
   iapd_drive_t core_drive, drive_out, drive_oe;
   iapd_local_t core_local, local_out;
   logic [7:0] exp_q[$];
   logic [7:0] exp_rd;
   logic exp_epp, exp_ecp;
   int error_cnt = 0;
   int checked = 0;
   always #5 mclk = ~mclk;
   iapd_host_bfm bfm (.mclk, .host);
   iapd_ctrl #(.IDLE_CYCLES(20), .NSER(2)) uut (.mclk, .rst_n, .host, .host_rdata,
      .status_a_live, .status_b_live, .main_status_live, .data_live, .dir_live, .fdc_int,
      .head_unload_done, .auto_power_config, .core_irq, .core_drq, .interrupt_request_out,
      .dma_request_out, .core_drive, .drive_out, .drive_oe, .drive_inputs_pin, .drive_inputs,
      .core_local, .local_out, .dmc_value, .ccr_value, .fdc_powered_down, .tx_buf_write,
      .tx_empty, .rx_fifo_empty, .rx_idle, .serial_receive_in, .ring_indicator_in,
      .ring_change, .tx_powered_down, .rx_powered_down, .epp_enabled, .ecp_enabled, .ecr_mode,
      .epp_powered_down, .ecp_powered_down);
   // ********************************
   // Tasks and read monitor
   // ********************************
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      bfm.xfer(1'b1, 1'b0, a, 8'h00);
   endtask : rd
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      bfm.xfer(1'b0, 1'b1, a, d);
   endtask : wr
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   always @(posedge mclk) rd_seen <= host.rd;
   always @(negedge mclk) begin
      if (rd_seen) begin
         // Take the note once, so a mismatch report cannot swallow the next one.
         exp_rd = exp_q.pop_front();
         `CHK(host_rdata, exp_rd)
      end
   end
   initial begin
      repeat (5000) @(posedge mclk);
      error_cnt++;
      wrap_up();
   end
   // ********************************
   // Scenarios
   // ********************************
   initial begin
      rst_n = 1'b0;
      {fdc_int, core_irq, core_drq, epp_enabled, ecp_enabled, ecr_mode} = '0;
      {tx_buf_write, tx_empty, rx_fifo_empty, rx_idle, serial_receive_in} = '0;
      ring_indicator_in = 2'h0;
      // Serial lines idle high, so the receiver sees no false edge out of reset.
      serial_receive_in = 2'h3;
      {auto_power_config, core_drive, core_local, drive_inputs_pin} = '0;
      {status_a_live, status_b_live, data_live, dir_live} = '0;
      main_status_live = `IAPD_MSR_IDLE;
      head_unload_done = 1'b1;
      void'($urandom(33));
      repeat (16) @(posedge mclk);
      @(negedge mclk);
      rst_n = 1'b1;
      `CHK(fdc_powered_down, 1'b0)
      `CHK(dmc_value, 8'h04)
      {status_a_live, status_b_live, dir_live, data_live} = $urandom;
      {core_drive, core_local, drive_inputs_pin} = 22'($urandom);
      {core_irq, core_drq} = 2'h3;
      auto_power_config = 8'h39;
      cyc(10);
      `CHK(fdc_powered_down, 1'b0)
      `CHK(drive_out, core_drive)
      `CHK(drive_oe, 10'h3ff)
      `CHK({interrupt_request_out, dma_request_out}, 2'h3)
      cyc(20);
      `CHK(fdc_powered_down, 1'b1)
      `CHK(drive_inputs, 6'h00)
      `CHK(drive_oe, 10'h000)
      `CHK({interrupt_request_out, dma_request_out}, 2'h0)
      `CHK(local_out, core_local)
      rd(3'h0, status_a_live);
      rd(3'h1, status_b_live);
      rd(3'h2, 8'h04);
      rd(3'h7, dir_live);
      wr(3'h2, 8'h0c);
      wr(3'h7, 8'h02);
      rd(3'h2, 8'h0c);
      `CHK(fdc_powered_down, 1'b1)
      `CHK(dmc_value, 8'h04)
      rd(3'h5, data_live);
      `CHK(fdc_powered_down, 1'b0)
      cyc(2);
      `CHK(dmc_value, 8'h0c)
      `CHK(ccr_value, 8'h02)
      cyc(30);
      `CHK(fdc_powered_down, 1'b1)
      wr(3'h2, 8'h1c);
      `CHK(fdc_powered_down, 1'b0)
      cyc(30);
      `CHK(fdc_powered_down, 1'b0)
      wr(3'h4, 8'h40);
      `CHK(fdc_powered_down, 1'b1)
      rd(3'h4, `IAPD_MSR_IDLE);
      `CHK(fdc_powered_down, 1'b0)
      wr(3'h2, 8'h0c);
      cyc(30);
      `CHK(fdc_powered_down, 1'b1)
      wr(3'h4, 8'h80);
      `CHK(fdc_powered_down, 1'b0)
      tx_empty = 2'h1;
      cyc(2);
      `CHK(tx_powered_down, 2'h1)
      tx_buf_write = 2'h1;
      cyc(1);
      tx_buf_write = 2'h0;
      auto_power_config = 8'h29;
      cyc(2);
      `CHK(tx_powered_down, 2'h0)
      {rx_fifo_empty, rx_idle} = 4'hf;
      cyc(2);
      `CHK(rx_powered_down, 2'h2)
      rx_idle = 2'h0;
      serial_receive_in = 2'h1;
      ring_indicator_in = 2'h1;
      cyc(2);
      `CHK(ring_change, 2'h1)
      cyc(3);
      `CHK(rx_powered_down, 2'h0)
      // Every enable pair meets every mode code, with the parallel enable off and on.
      for (int m = 0; m < 64; m++) begin
         {auto_power_config[3], epp_enabled, ecp_enabled, ecr_mode} = m[5:0];
         exp_epp = auto_power_config[3] && (!epp_enabled ||
                   (ecp_enabled && ecr_mode != `IAPD_ECR_EPP));
         exp_ecp = auto_power_config[3] && (!ecp_enabled ||
                   ecr_mode inside {`IAPD_ECR_SPP, `IAPD_ECR_BIDIR, `IAPD_ECR_EPP});
         cyc(2);
         `CHK(epp_powered_down, exp_epp)
         `CHK(ecp_powered_down, exp_ecp)
      end
      wrap_up();
   end
endmodule : tb_io_auto_powerdown_control
